// ### irq_bridge.sv
// What this block does
// - handle level only when its enable set
// - enabled asserted line: get bus, acknowledge
// - on done store vector, set status, interrupt
// - no new acknowledge until status cleared
// - enable bits gate each source's interrupt
// - soft enable rising sets soft status
// - soft enable cleared masks, status kept
// - location monitor enables in bits 23:20
// - mailbox enables in bits 19:16
// - byte 15:8 holds fail, soft, error enables
// - dma and error sources need enable
// - ownership bit 0, levels bits 7:1
// - status latches event, write one clears
// - fail status clear ignored while pin asserted
// - each source routed by 3-bit map code
//
// Decided for this implementation: the APB register port.
module irq_bridge #(
    parameter int VEC_W = 8
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [7:1]          vme_request_level_n,
    input  wire logic                acfail_n,
    input  wire logic                sysfail_n,
    input  wire logic [3:0]          loc_monitor_event,
    input  wire logic [3:0]          mailbox_event,
    input  wire logic                vme_soft_ack_event,
    input  wire logic                vme_error_event,
    input  wire logic                pci_error_event,
    input  wire logic                dma_event,
    input  wire logic                vme_ownership_event,
    output logic                     vme_bus_req,
    input  wire logic                vme_bus_grant,
    output logic                     vme_iack_req,
    output logic      [2:0]          vme_iack_level,
    input  wire logic                vme_iack_done,
    input  wire logic [VEC_W-1:0]    vme_iack_vector,
    output logic      [7:0]          pci_irq_output
);
    localparam int NS = irq_bridge_pkg::NUM_SRC;
    localparam int CW = irq_bridge_pkg::MAP_CODE_W;
    localparam int FW = irq_bridge_pkg::MAP_FIELD_W;

    logic [31:0]          local_irq_enable_reg;
    logic [NS-1:0]        local_irq_status_reg;
    logic [NS-1:0]        status_next;
    logic [31:0]          map0_reg;
    logic [31:0]          map1_reg;
    logic [31:0]          map2_reg;
    logic [VEC_W-1:0]     vme_vector_capture_reg [1:7];
    logic [7:1]           level_n_sync;
    logic [1:0]           fail_n_sync;
    logic [7:1]           level_active;
    logic                 acfail_active;
    logic                 sysfail_active;
    logic [7:1]           level_pending;
    logic [2:0]           level_pick;
    logic [NS-1:0]        set_vec;
    logic [NS-1:0]        clr_vec;
    logic [NS-1:0]        src_active;
    logic [NS*CW-1:0]     src_code;
    logic                 wr_stb;
    logic                 setup_stb;
    logic                 vec_hit;
    logic [2:0]           vec_idx;
    logic                 addr_ok;
    logic [31:0]          read_value;
    logic                 iack_finish;
    irq_bridge_pkg::handler_state_t state_reg;

    pin_sync #(.WIDTH(7)) u_level_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .pin_in    (vme_request_level_n),
        .pin_out   (level_n_sync),
        .rst_value (7'h7F)
    );

    pin_sync #(.WIDTH(2)) u_fail_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .pin_in    ({acfail_n, sysfail_n}),
        .pin_out   (fail_n_sync),
        .rst_value (2'h3)
    );

    assign level_active   = ~level_n_sync;
    assign acfail_active  = ~fail_n_sync[1];
    assign sysfail_active = ~fail_n_sync[0];

    // apb: zero wait states, read data flopped in the setup cycle
    assign pready    = 1'b1;
    assign wr_stb    = psel && penable && pwrite && !pslverr;
    assign setup_stb = psel && !penable;
    assign vec_hit   = paddr >= irq_bridge_pkg::ADDR_VEC_BASE + 12'h004
                    && paddr <= irq_bridge_pkg::ADDR_VEC_BASE + 12'h01C
                    && paddr[1:0] == 2'h0;
    assign vec_idx   = 3'((paddr - irq_bridge_pkg::ADDR_VEC_BASE) >> 2);

    always_comb begin
        addr_ok    = 1'b1;
        read_value = 32'h0000_0000;
        unique case (paddr)
            irq_bridge_pkg::ADDR_ENABLE: read_value = local_irq_enable_reg;
            irq_bridge_pkg::ADDR_STATUS: read_value = 32'(local_irq_status_reg);
            irq_bridge_pkg::ADDR_MAP0:   read_value = map0_reg;
            irq_bridge_pkg::ADDR_MAP1:   read_value = map1_reg;
            irq_bridge_pkg::ADDR_MAP2:   read_value = map2_reg;
            default: begin
                if (vec_hit) begin
                    read_value = 32'(vme_vector_capture_reg[vec_idx]);
                end else begin
                    addr_ok = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_stb) begin
            prdata  <= pwrite ? 32'h0000_0000 : read_value;
            pslverr <= !addr_ok;
        end
    end

    // enable register; reserved bits never stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            local_irq_enable_reg <= irq_bridge_pkg::ENABLE_RESET;
        end else if (wr_stb && paddr == irq_bridge_pkg::ADDR_ENABLE) begin
            local_irq_enable_reg <= pwdata & irq_bridge_pkg::ENABLE_WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            map0_reg <= irq_bridge_pkg::MAP_RESET;
            map1_reg <= irq_bridge_pkg::MAP_RESET;
            map2_reg <= irq_bridge_pkg::MAP_RESET;
        end else if (wr_stb) begin
            if (paddr == irq_bridge_pkg::ADDR_MAP0) begin
                map0_reg <= pwdata & irq_bridge_pkg::MAP0_WR_MASK;
            end
            if (paddr == irq_bridge_pkg::ADDR_MAP1) begin
                map1_reg <= pwdata & irq_bridge_pkg::MAP1_WR_MASK;
            end
            if (paddr == irq_bridge_pkg::ADDR_MAP2) begin
                map2_reg <= pwdata & irq_bridge_pkg::MAP2_WR_MASK;
            end
        end
    end

    // status events
    always_comb begin
        set_vec = '0;
        set_vec[irq_bridge_pkg::BIT_LMON0 +: 4] = loc_monitor_event;
        set_vec[irq_bridge_pkg::BIT_MAILBOX0_EN +: 4] = mailbox_event;
        set_vec[irq_bridge_pkg::BIT_ACFAIL]     = acfail_active;
        set_vec[irq_bridge_pkg::BIT_SYSFAIL]    = sysfail_active;
        set_vec[irq_bridge_pkg::BIT_SOFT]       = wr_stb && paddr == irq_bridge_pkg::ADDR_ENABLE
            && pwdata[irq_bridge_pkg::BIT_SOFT]
            && !local_irq_enable_reg[irq_bridge_pkg::BIT_SOFT];
        set_vec[irq_bridge_pkg::BIT_SOFT_ACK]   = vme_soft_ack_event;
        set_vec[irq_bridge_pkg::BIT_VME_ERR]    = vme_error_event;
        set_vec[irq_bridge_pkg::BIT_PCI_ERR]    = pci_error_event;
        set_vec[irq_bridge_pkg::BIT_DMA]        = dma_event;
        set_vec[irq_bridge_pkg::BIT_OWN]        = vme_ownership_event;
        if (iack_finish) begin
            set_vec[vme_iack_level] = 1'b1;
        end
        clr_vec = '0;
        if (wr_stb && paddr == irq_bridge_pkg::ADDR_STATUS) begin
            clr_vec = pwdata[NS-1:0];
        end
        clr_vec[irq_bridge_pkg::BIT_RSVD] = 1'b0;
        // fail bits are level sensitive
        if (acfail_active) begin
            clr_vec[irq_bridge_pkg::BIT_ACFAIL] = 1'b0;
        end
        if (sysfail_active) begin
            clr_vec[irq_bridge_pkg::BIT_SYSFAIL] = 1'b0;
        end
        status_next = (local_irq_status_reg & ~clr_vec) | set_vec;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            local_irq_status_reg <= '0;
        end else begin
            local_irq_status_reg <= status_next;
        end
    end

    // interrupt handler: highest pending level first
    assign level_pending = local_irq_enable_reg[7:1] & level_active
                         & ~local_irq_status_reg[7:1];

    always_comb begin
        level_pick = 3'h0;
        for (int l = irq_bridge_pkg::FIRST_LEVEL; l <= irq_bridge_pkg::LAST_LEVEL; l++) begin
            if (level_pending[l]) begin
                level_pick = 3'(l);
            end
        end
    end

    assign iack_finish = state_reg == irq_bridge_pkg::HANDLER_IACK && vme_iack_done;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg      <= irq_bridge_pkg::HANDLER_IDLE;
            vme_bus_req    <= 1'b0;
            vme_iack_req   <= 1'b0;
            vme_iack_level <= 3'h0;
        end else begin
            unique case (state_reg)
                irq_bridge_pkg::HANDLER_IDLE: begin
                    if (level_pick != 3'h0) begin
                        state_reg      <= irq_bridge_pkg::HANDLER_BUS_REQ;
                        vme_bus_req    <= 1'b1;
                        vme_iack_level <= level_pick;
                    end
                end
                irq_bridge_pkg::HANDLER_BUS_REQ: begin
                    if (vme_bus_grant) begin
                        state_reg    <= irq_bridge_pkg::HANDLER_IACK;
                        vme_iack_req <= 1'b1;
                    end
                end
                irq_bridge_pkg::HANDLER_IACK: begin
                    if (vme_iack_done) begin
                        state_reg    <= irq_bridge_pkg::HANDLER_IDLE;
                        vme_bus_req  <= 1'b0;
                        vme_iack_req <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= irq_bridge_pkg::HANDLER_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int l = irq_bridge_pkg::FIRST_LEVEL; l <= irq_bridge_pkg::LAST_LEVEL; l++) begin
                vme_vector_capture_reg[l] <= '0;
            end
        end else if (iack_finish) begin
            vme_vector_capture_reg[vme_iack_level] <= vme_iack_vector;
        end
    end

    // per-source map code: map0 sources 0-7, map1 sources 8-15, map2 sources 16-23, low 3 bits of each nibble
    always_comb begin
        src_code = '0;
        for (int b = 0; b < 8; b++) begin
            src_code[b*CW +: CW]      = map0_reg[b*FW +: CW];
            src_code[(b+8)*CW +: CW]  = map1_reg[b*FW +: CW];
            src_code[(b+16)*CW +: CW] = map2_reg[b*FW +: CW];
        end
    end

    assign src_active = local_irq_status_reg & local_irq_enable_reg[NS-1:0];

    irq_router u_router (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .src_active (src_active),
        .src_code   (src_code),
        .irq_out    (pci_irq_output)
    );

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_NO_REQ_WHEN_DISABLED: assert property (
        state_reg == irq_bridge_pkg::HANDLER_IDLE && !vme_bus_req
        && (local_irq_enable_reg[7:1] & level_active) == 7'h00 |=> !vme_bus_req)
        else $error("bus requested with no enabled level");
    AST_REQ_ON_PENDING: assert property (
        state_reg == irq_bridge_pkg::HANDLER_IDLE && level_pending != 7'h00
        |=> vme_bus_req && local_irq_enable_reg[vme_iack_level])
        else $error("pending enabled level not requested");
    AST_IACK_AFTER_GRANT: assert property (
        state_reg == irq_bridge_pkg::HANDLER_BUS_REQ && vme_bus_grant |=> vme_iack_req)
        else $error("no acknowledge after grant");
    AST_VECTOR_STORED: assert property (
        iack_finish |=> local_irq_status_reg[vme_iack_level]
        && vme_vector_capture_reg[vme_iack_level] == $past(vme_iack_vector) && !vme_bus_req)
        else $error("vector or status not stored on acknowledge");
    AST_NO_REPEAT_LEVEL: assert property (
        $rose(vme_bus_req) |-> !local_irq_status_reg[vme_iack_level])
        else $error("acknowledge started for level with status set");
    AST_SOFT_RISE: assert property (
        wr_stb && paddr == irq_bridge_pkg::ADDR_ENABLE && pwdata[irq_bridge_pkg::BIT_SOFT]
        && !local_irq_enable_reg[irq_bridge_pkg::BIT_SOFT] |=> local_irq_status_reg[irq_bridge_pkg::BIT_SOFT])
        else $error("soft enable rise did not set status");
    AST_SOFT_KEEP: assert property (
        local_irq_status_reg[irq_bridge_pkg::BIT_SOFT] && !clr_vec[irq_bridge_pkg::BIT_SOFT]
        |=> local_irq_status_reg[irq_bridge_pkg::BIT_SOFT])
        else $error("soft status lost without clear");
    AST_ACFAIL_HOLD: assert property (
        acfail_active |=> local_irq_status_reg[irq_bridge_pkg::BIT_ACFAIL])
        else $error("acfail status cleared while pin asserted");
    AST_RESERVED_ZERO: assert property (
        local_irq_enable_reg[31:24] == 8'h00 && !local_irq_enable_reg[irq_bridge_pkg::BIT_RSVD])
        else $error("reserved enable bits not zero");
    AST_MASKED_SILENT: assert property (
        local_irq_enable_reg[NS-1:0] == '0 |=> pci_irq_output == 8'h00)
        else $error("masked sources reached an output");
endmodule // irq_bridge

// ### irq_bridge_pkg.sv
package irq_bridge_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_ENABLE   = 12'h300;
    localparam logic [11:0] ADDR_STATUS   = 12'h304;
    localparam logic [11:0] ADDR_MAP0     = 12'h308;
    localparam logic [11:0] ADDR_MAP1     = 12'h30C;
    localparam logic [11:0] ADDR_MAP2     = 12'h310;
    localparam logic [11:0] ADDR_VEC_BASE = 12'h320;

    localparam logic [31:0] ENABLE_RESET   = 32'h0000_0000;
    localparam logic [31:0] ENABLE_WR_MASK = 32'h00FF_F7FF;
    localparam logic [31:0] MAP_RESET      = 32'h0000_0000;
    localparam logic [31:0] MAP0_WR_MASK   = 32'h7777_7777;
    localparam logic [31:0] MAP1_WR_MASK   = 32'h7777_0777;
    localparam logic [31:0] MAP2_WR_MASK   = 32'h7777_7777;

    localparam int NUM_SRC      = 24;
    localparam int MAP_CODE_W   = 3;
    localparam int MAP_FIELD_W  = 4;
    localparam int NUM_OUT      = 8;
    localparam int FIRST_LEVEL  = 1;
    localparam int LAST_LEVEL   = 7;

    // bit positions in enable and status
    localparam int BIT_OWN      = 0;
    localparam int BIT_DMA      = 8;
    localparam int BIT_PCI_ERR  = 9;
    localparam int BIT_VME_ERR  = 10;
    localparam int BIT_RSVD     = 11;
    localparam int BIT_SOFT_ACK = 12;
    localparam int BIT_SOFT     = 13;
    localparam int BIT_SYSFAIL  = 14;
    localparam int BIT_ACFAIL   = 15;
    localparam int BIT_MAILBOX0_EN    = 16;
    localparam int BIT_LMON0    = 20;

    typedef enum logic [1:0] {
        HANDLER_IDLE,
        HANDLER_BUS_REQ,
        HANDLER_IACK
    } handler_state_t;
endpackage

// ### pin_sync.sv
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    input  wire logic [WIDTH-1:0] rst_value
);
    logic [WIDTH-1:0] stage1_reg;

    // pin_out is only the second flop; stage1 feeds nothing else
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1_reg <= rst_value;
            pin_out    <= rst_value;
        end else begin
            stage1_reg <= pin_in;
            pin_out    <= stage1_reg;
        end
    end
endmodule // pin_sync

// ### irq_router.sv
module irq_router #(
    parameter int NUM_SRC = irq_bridge_pkg::NUM_SRC,
    parameter int NUM_OUT = irq_bridge_pkg::NUM_OUT,
    parameter int CODE_W  = irq_bridge_pkg::MAP_CODE_W
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic [NUM_SRC-1:0]        src_active,
    input  wire logic [NUM_SRC*CODE_W-1:0] src_code,
    output logic      [NUM_OUT-1:0]        irq_out
);
    logic [NUM_OUT-1:0] irq_next;

    always_comb begin
        irq_next = '0;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (src_active[s]) begin
                irq_next[src_code[s*CODE_W +: CODE_W]] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_out <= '0;
        end else begin
            irq_out <= irq_next;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_ROUTE_CODE_ZERO: assert property (
        src_active[0] && src_code[CODE_W-1:0] == '0 |=> irq_out[0])
        else $error("source with code 0 did not reach output 0");
endmodule // irq_router

// ### vme_irq_partner.sv
module vme_irq_partner #(
    parameter logic [7:0] VEC_BASE = 8'hA0
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:1] req_lines,
    input  wire logic [3:0] dly,
    input  wire logic       vme_bus_req,
    input  wire logic       vme_iack_req,
    input  wire logic [2:0] vme_iack_level,
    output logic      [7:1] vme_request_level_n,
    output logic            vme_bus_grant,
    output logic            vme_iack_done,
    output logic      [7:0] vme_iack_vector
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] cnt_reg;
    logic [7:0] noise_reg;

    assign vme_request_level_n = ~req_lines;
    // vector is only meaningful with done, otherwise it churns
    assign vme_iack_vector = vme_iack_done ? VEC_BASE + {5'h00, vme_iack_level} : noise_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_reg       <= 4'h0;
            noise_reg     <= 8'h5A;
            vme_bus_grant <= 1'b0;
            vme_iack_done <= 1'b0;
        end else begin
            noise_reg     <= noise_reg + 8'h35;
            vme_iack_done <= 1'b0;
            if (!vme_bus_req) begin
                vme_bus_grant <= 1'b0;
                cnt_reg       <= 4'h0;
            end else if (!vme_bus_grant) begin
                cnt_reg       <= (cnt_reg == dly) ? 4'h0 : cnt_reg + 4'h1;
                vme_bus_grant <= (cnt_reg == dly);
            end else if (vme_iack_req && !vme_iack_done) begin
                cnt_reg       <= (cnt_reg == dly) ? 4'h0 : cnt_reg + 4'h1;
                vme_iack_done <= (cnt_reg == dly);
            end
        end
    end
endmodule // vme_irq_partner

// ### tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, vme_bus_req, vme_bus_grant, vme_iack_req, vme_iack_done, seen;
    logic [2:0]  vme_iack_level;
    logic [7:0]  vme_iack_vector, pci_irq_output, code;
    logic [7:1]  req = 7'h00, vme_request_level_n;
    logic [3:0]  dly = 4'h0;
    logic [23:0] ev = 24'h0;
    logic [1:0]  fail_n = 2'b11;
    logic [32:0] exp_q[$];
    logic [31:0] seed = 32'h0000_0020;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    int srcs[11] = '{0, 8, 9, 10, 12, 16, 17, 18, 19, 20, 23};

    always #25 clk = ~clk;

    irq_bridge uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vme_request_level_n(vme_request_level_n), .acfail_n(fail_n[0]), .sysfail_n(fail_n[1]),
        .loc_monitor_event(ev[23:20]), .mailbox_event(ev[19:16]), .vme_soft_ack_event(ev[12]),
        .vme_error_event(ev[10]), .pci_error_event(ev[9]), .dma_event(ev[8]),
        .vme_ownership_event(ev[0]), .vme_bus_req(vme_bus_req), .vme_bus_grant(vme_bus_grant),
        .vme_iack_req(vme_iack_req), .vme_iack_level(vme_iack_level), .vme_iack_done(vme_iack_done),
        .vme_iack_vector(vme_iack_vector), .pci_irq_output(pci_irq_output));

    vme_irq_partner far_side (.clk(clk), .sys_rst(sys_rst), .req_lines(req), .dly(dly),
        .vme_bus_req(vme_bus_req), .vme_iack_req(vme_iack_req), .vme_iack_level(vme_iack_level),
        .vme_request_level_n(vme_request_level_n), .vme_bus_grant(vme_bus_grant),
        .vme_iack_done(vme_iack_done), .vme_iack_vector(vme_iack_vector));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d of %0d comparisons", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // setup, then access until pready; read expectation is {pslverr, prdata}
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic irq_chk(input int n, input logic [7:0] e);
        repeat (n) @(posedge clk);
        @(negedge clk);
        check(pci_irq_output, e);
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) check(33'h0, 33'h1_FFFF_FFFF);
            else check({pslverr, prdata}, exp_q.pop_front());
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            end_sim();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        apb(0, irq_bridge_pkg::ADDR_ENABLE, 0, 33'h0);
        apb(0, irq_bridge_pkg::ADDR_STATUS, 0, 33'h0);
        apb(1, irq_bridge_pkg::ADDR_ENABLE, 32'hFFFF_FFFF, 0);
        apb(0, irq_bridge_pkg::ADDR_ENABLE, 0, {1'b0, 32'h00FF_F7FF});
        apb(1, irq_bridge_pkg::ADDR_ENABLE, 32'h0, 0);
        apb(0, 12'h3FC, 0, {1'b1, 32'h0});
        apb(0, irq_bridge_pkg::ADDR_STATUS, 0, 33'h1 << irq_bridge_pkg::BIT_SOFT);
        apb(1, irq_bridge_pkg::ADDR_STATUS, 32'hFF_FFFF, 0);
        apb(1, irq_bridge_pkg::ADDR_MAP0, 32'hFFFF_FFFF, 0);
        apb(0, irq_bridge_pkg::ADDR_MAP0, 0, {1'b0, 32'h7777_7777});
        apb(1, irq_bridge_pkg::ADDR_MAP2, 32'hFFFF_FFFF, 0);
        apb(0, irq_bridge_pkg::ADDR_MAP2, 0, {1'b0, 32'h7777_7777});
        apb(1, irq_bridge_pkg::ADDR_MAP0, 32'h0, 0);
        apb(1, irq_bridge_pkg::ADDR_MAP2, 32'h0, 0);
        foreach (srcs[i]) begin
            ev[srcs[i]] <= 1'b1;
            @(posedge clk);
            ev <= 24'h0;
            irq_chk(2, 8'h00);
            apb(0, irq_bridge_pkg::ADDR_STATUS, 0, 33'h1 << srcs[i]);
            apb(1, irq_bridge_pkg::ADDR_ENABLE, 32'h1 << srcs[i], 0);
            irq_chk(1, 8'h01);
            apb(1, irq_bridge_pkg::ADDR_STATUS, 32'h1 << srcs[i], 0);
            irq_chk(1, 8'h00);
            apb(1, irq_bridge_pkg::ADDR_ENABLE, 32'h0, 0);
        end
        repeat (4) begin
            code = 8'(xs() % 8);
            apb(1, irq_bridge_pkg::ADDR_MAP1, {24'h0, code}, 0);
            apb(0, irq_bridge_pkg::ADDR_MAP1, 0, {25'h0, code});
            apb(1, irq_bridge_pkg::ADDR_ENABLE, 32'h1 << irq_bridge_pkg::BIT_DMA, 0);
            ev[8] <= 1'b1;
            @(posedge clk);
            ev <= 24'h0;
            irq_chk(2, 8'h01 << code);
            apb(1, irq_bridge_pkg::ADDR_STATUS, 32'hFF_FFFF, 0);
            irq_chk(1, 8'h00);
        end
        apb(1, irq_bridge_pkg::ADDR_MAP1, 32'h0, 0);
        apb(1, irq_bridge_pkg::ADDR_ENABLE, 32'h1 << irq_bridge_pkg::BIT_SOFT, 0);
        apb(0, irq_bridge_pkg::ADDR_STATUS, 0, 33'h1 << irq_bridge_pkg::BIT_SOFT);
        irq_chk(0, 8'h01);
        apb(1, irq_bridge_pkg::ADDR_ENABLE, 32'h0, 0);
        irq_chk(1, 8'h00);
        apb(0, irq_bridge_pkg::ADDR_STATUS, 0, 33'h1 << irq_bridge_pkg::BIT_SOFT);
        apb(1, irq_bridge_pkg::ADDR_STATUS, 32'hFF_FFFF, 0);
        for (int i = 0; i < 2; i++) begin
            fail_n[i] <= 1'b0;
            repeat (4) @(posedge clk);
            apb(1, irq_bridge_pkg::ADDR_STATUS, 32'h1 << (15 - i), 0);
            apb(0, irq_bridge_pkg::ADDR_STATUS, 0, 33'h1 << (15 - i));
            fail_n[i] <= 1'b1;
            repeat (4) @(posedge clk);
            apb(1, irq_bridge_pkg::ADDR_STATUS, 32'h1 << (15 - i), 0);
            apb(0, irq_bridge_pkg::ADDR_STATUS, 0, 33'h0);
        end
        req[7] <= 1'b1;
        seen = 1'b0;
        repeat (20) begin
            @(posedge clk);
            if (vme_bus_req === 1'b1) seen = 1'b1;
        end
        check(seen, 1'b0);
        req <= 7'h00;
        repeat (4) @(posedge clk);
        for (int l = 1; l <= 7; l++) begin
            dly <= 4'(xs() % 8);
            apb(1, irq_bridge_pkg::ADDR_ENABLE, 32'h1 << l, 0);
            req[l] <= 1'b1;
            for (int k = 0; k < 20 && vme_bus_req !== 1'b1; k++) @(posedge clk);
            check(vme_bus_req, 1'b1);
            check(vme_iack_level, l);
            for (int k = 0; k < 40 && vme_iack_req !== 1'b1; k++) @(posedge clk);
            check(vme_iack_req, 1'b1);
            for (int k = 0; k < 40 && vme_bus_req === 1'b1; k++) @(posedge clk);
            seen = 1'b0;
            repeat (10) begin
                @(posedge clk);
                if (vme_bus_req === 1'b1) seen = 1'b1;
            end
            check(seen, 1'b0);
            req <= 7'h00;
            apb(0, irq_bridge_pkg::ADDR_STATUS, 0, 33'h1 << l);
            apb(0, irq_bridge_pkg::ADDR_VEC_BASE + 12'(4 * l), 0, 33'h0A0 + l);
            irq_chk(0, 8'h01);
            repeat (3) @(posedge clk);
            apb(1, irq_bridge_pkg::ADDR_STATUS, 32'h1 << l, 0);
            irq_chk(1, 8'h00);
        end
        repeat (3) @(posedge clk);
        end_sim();
    end
endmodule // tb_top
